// ---- eee_pkg.sv ----
// Constants for the global energy-efficient Ethernet indirect register bank.
// Assumes byte-wide host register access and one system clock.
package eee_pkg;
  // Directly addressed host registers
  localparam logic [7:0] SEL_ADDR = 8'h6E;
  localparam logic [7:0] OFF_ADDR = 8'h6F;
  localparam logic [7:0] DATA_ADDR = 8'hA0;
  // Table select fields
  localparam int SEL_BANK_MSB = 7;
  localparam int SEL_BANK_LSB = 5;
  localparam int SEL_TABLE_MSB = 3;
  localparam int SEL_TABLE_LSB = 0;
  localparam logic [2:0] BANK_EEE = 3'h1;
  localparam logic [3:0] TABLE_GLOBAL = 4'h0;
  // Global register byte offsets (even offset is the high byte)
  localparam logic [7:0] OFF_NEXT_PAGE = 8'h34;
  localparam logic [7:0] OFF_MIN_LPI = 8'h36;
  localparam logic [7:0] OFF_WAKE_THR = 8'h38;
  localparam logic [7:0] OFF_DIAG_CTRL = 8'h3A;
  // Field layout and reset values
  localparam int PORTS = 4;
  localparam int NP_LSB = 0;
  localparam logic [11:0] NP_FIXED_HI = 12'h680;
  localparam logic [3:0] NP_RESET = 4'hF;
  localparam logic [15:0] MIN_LPI_RESET = 16'h0000;
  localparam logic [15:0] WAKE_THR_RESET = 16'h0201;
  localparam logic [15:0] DIAG_CTRL_RESET = 16'h0001;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] OFF_RESET = 8'h00;
  // Wake-up duration counter
  localparam int WAKE_CNT_W = 16;
  localparam logic [15:0] WAKE_CNT_MAX = 16'hFFFF;
endpackage

// ---- wake_if.sv ----
// Carrier between the register bank and the wake-up duration monitor.
// Assumes both ends sit on the same system clock.
`timescale 1ns/100ps
interface wake_if;
  logic [3:0] active;
  logic [15:0] threshold;
  logic [3:0] err;
  modport mon (input active, input threshold, output err);
  modport ctl (output active, output threshold, input err);
endinterface

// ---- wake_monitor.sv ----
// Per-port PHY wake-up duration monitor.
// Assumes wake-active levels are synchronous to CLOCK.
`timescale 1ns/100ps
module wake_monitor (
  input wire logic CLOCK,
  input wire logic RST,
  wake_if.mon wif
);
  typedef struct packed {
    logic [eee_pkg::PORTS-1:0][eee_pkg::WAKE_CNT_W-1:0] cnt;
    logic [eee_pkg::PORTS-1:0] fired;
    logic [eee_pkg::PORTS-1:0] err;
  } mon_s;

  mon_s state_ff;
  mon_s nxt_state;

  // Duration count, one error pulse per overlong wake-up
  always_comb begin
    nxt_state = state_ff;
    for (int p = 0; p < eee_pkg::PORTS; p++) begin
      nxt_state.err[p] = 1'b0;
      if (wif.active[p]) begin
        if (state_ff.cnt[p] != eee_pkg::WAKE_CNT_MAX) begin
          nxt_state.cnt[p] = state_ff.cnt[p] + 16'h0001;
        end
        if (!state_ff.fired[p] && state_ff.cnt[p] == wif.threshold) begin
          nxt_state.err[p] = 1'b1;
          nxt_state.fired[p] = 1'b1;
        end
      end else begin
        nxt_state.cnt[p] = '0;
        nxt_state.fired[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wif.err = state_ff.err;

  chk_err_after_thr: assert property (@(posedge CLOCK) disable iff (RST)
    (wif.active[0] && !state_ff.fired[0] && state_ff.cnt[0] == wif.threshold) |=> wif.err[0])
    else $error("wake error not raised when threshold exceeded");

  chk_err_cause_only: assert property (@(posedge CLOCK) disable iff (RST)
    wif.err[1] |-> ($past(state_ff.cnt[1]) == $past(wif.threshold) && $past(wif.active[1])))
    else $error("wake error raised without exceeding threshold");

  chk_err_single_pulse: assert property (@(posedge CLOCK) disable iff (RST)
    wif.err[0] |=> !wif.err[0])
    else $error("wake error pulse longer than one cycle");
endmodule // wake_monitor

// ---- eee_global_indirect_regs.sv ----
// Global EEE indirect register bank with table select, byte offset and data byte.
// Assumes a host that issues single-cycle byte reads and writes on CLOCK.
`timescale 1ns/100ps
// Behaviour
// - Bank reached only with select 001 and 0x0
// - Offset byte steers data byte reads, writes
// - Even offset high byte, odd offset low
// - Next-page enable bits drive auto-negotiation per port
// - Enables in low nibble at 0x34 word
// - Enables reset to all ones
// - Threshold bounds allowed PHY wake-up time
// - Overlong wake-up pulses error count increment
// - Threshold read-only, resets to 0x0201
module eee_global_indirect_regs (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic [3:0] NP_ENABLE,
  input wire logic [3:0] WAKE_ACTIVE,
  output logic [3:0] WAKE_ERR_INC
);
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] off;
    logic [3:0] np;
    logic [7:0] rdata;
    logic rvalid;
  } bank_s;

  bank_s state_ff;
  bank_s nxt_state;
  logic bank_hit;
  logic data_wr;
  logic data_rd;

  wake_if wif();

  // Table select decode
  function automatic logic is_global(input logic [7:0] sel);
    return sel[eee_pkg::SEL_BANK_MSB:eee_pkg::SEL_BANK_LSB] == eee_pkg::BANK_EEE
        && sel[eee_pkg::SEL_TABLE_MSB:eee_pkg::SEL_TABLE_LSB] == eee_pkg::TABLE_GLOBAL;
  endfunction

  // Byte of a 16-bit word by offset parity
  function automatic logic [7:0] word_byte(input logic [15:0] word, input logic odd);
    return odd ? word[7:0] : word[15:8];
  endfunction

  // Readback of the global bank
  function automatic logic [7:0] bank_byte(input logic [7:0] off, input logic [3:0] np);
    logic [7:0] base;
    logic [7:0] val;
    base = {off[7:1], 1'b0};
    val = 8'h00;
    case (base)
      eee_pkg::OFF_NEXT_PAGE: val = word_byte({eee_pkg::NP_FIXED_HI, np}, off[0]);
      eee_pkg::OFF_MIN_LPI: val = word_byte(eee_pkg::MIN_LPI_RESET, off[0]);
      eee_pkg::OFF_WAKE_THR: val = word_byte(eee_pkg::WAKE_THR_RESET, off[0]);
      eee_pkg::OFF_DIAG_CTRL: val = word_byte(eee_pkg::DIAG_CTRL_RESET, off[0]);
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  assign bank_hit = is_global(state_ff.sel);
  assign data_wr = REG_WR && REG_ADDR == eee_pkg::DATA_ADDR && bank_hit;
  assign data_rd = REG_RD && REG_ADDR == eee_pkg::DATA_ADDR && bank_hit;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rvalid = REG_RD;
    if (REG_WR) begin
      case (REG_ADDR)
        eee_pkg::SEL_ADDR: nxt_state.sel = REG_WDATA;
        eee_pkg::OFF_ADDR: nxt_state.off = REG_WDATA;
        default: nxt_state.sel = state_ff.sel;
      endcase
    end
    // Only the enable nibble is writable; other words ignore writes
    if (data_wr && state_ff.off == (eee_pkg::OFF_NEXT_PAGE | 8'h01)) begin
      nxt_state.np = REG_WDATA[3:0];
    end
    if (REG_RD) begin
      case (REG_ADDR)
        eee_pkg::SEL_ADDR: nxt_state.rdata = state_ff.sel;
        eee_pkg::OFF_ADDR: nxt_state.rdata = state_ff.off;
        eee_pkg::DATA_ADDR: nxt_state.rdata = data_rd ? bank_byte(state_ff.off, state_ff.np) : 8'h00;
        default: nxt_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff.sel <= eee_pkg::SEL_RESET;
      state_ff.off <= eee_pkg::OFF_RESET;
      state_ff.np <= eee_pkg::NP_RESET;
      state_ff.rdata <= 8'h00;
      state_ff.rvalid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wif.active = WAKE_ACTIVE;
  assign wif.threshold = eee_pkg::WAKE_THR_RESET;

  wake_monitor u_wake (
    .CLOCK(CLOCK),
    .RST(RST),
    .wif(wif)
  );

  assign REG_RDATA = state_ff.rdata;
  assign REG_RVALID = state_ff.rvalid;
  assign NP_ENABLE = state_ff.np;
  assign WAKE_ERR_INC = wif.err;

  // Checks
  chk_bank_gate: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_RD && REG_ADDR == eee_pkg::DATA_ADDR && !is_global(state_ff.sel)) |=> (REG_RDATA == 8'h00 && REG_RVALID))
    else $error("data read outside the global bank returned nonzero");

  chk_bank_no_write: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_WR && REG_ADDR == eee_pkg::DATA_ADDR && !is_global(state_ff.sel)) |=> $stable(NP_ENABLE))
    else $error("write outside the global bank changed enables");

  chk_offset_route: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_WR && REG_ADDR == eee_pkg::OFF_ADDR) |=> (state_ff.off == $past(REG_WDATA)))
    else $error("offset byte not captured");

  chk_even_high: assert property (@(posedge CLOCK) disable iff (RST)
    (data_rd && state_ff.off == eee_pkg::OFF_WAKE_THR) |=> REG_RDATA == 8'h02)
    else $error("even offset did not return the high byte");

  chk_np_drive: assert property (@(posedge CLOCK) disable iff (RST)
    (data_wr && state_ff.off == 8'h35) |=> NP_ENABLE == $past(REG_WDATA[3:0]))
    else $error("enable write did not reach the ports");

  chk_np_readback: assert property (@(posedge CLOCK) disable iff (RST)
    (data_rd && state_ff.off == 8'h35) |=> REG_RDATA == {4'h0, $past(NP_ENABLE)})
    else $error("enable nibble readback wrong");

  chk_np_reset: assert property (@(posedge CLOCK)
    RST |=> NP_ENABLE == 4'hF)
    else $error("enables not all ones after reset");

  chk_thr_fixed: assert property (@(posedge CLOCK) disable iff (RST)
    (data_rd && state_ff.off == 8'h39) |=> REG_RDATA == 8'h01)
    else $error("threshold low byte not fixed");

  chk_rsvd_fixed: assert property (@(posedge CLOCK) disable iff (RST)
    (data_rd && state_ff.off == 8'h3B) |=> REG_RDATA == 8'h01)
    else $error("reserved diagnostic word not fixed");

  chk_rsvd_lpi: assert property (@(posedge CLOCK) disable iff (RST)
    (data_rd && (state_ff.off == 8'h36 || state_ff.off == 8'h37)) |=> REG_RDATA == 8'h00)
    else $error("reserved lpi word not zero");

  chk_diag_high_byte: assert property (@(posedge CLOCK) disable iff (RST)
    (data_rd && state_ff.off == eee_pkg::OFF_DIAG_CTRL) |=> REG_RDATA == 8'h00)
    else $error("reserved diagnostic high byte not zero");

  chk_np_high_byte: assert property (@(posedge CLOCK) disable iff (RST)
    (data_rd && state_ff.off == eee_pkg::OFF_NEXT_PAGE) |=> REG_RDATA == 8'h68)
    else $error("enable word high byte wrong");

  chk_np_hold: assert property (@(posedge CLOCK) disable iff (RST)
    !(data_wr && state_ff.off == (eee_pkg::OFF_NEXT_PAGE | 8'h01)) |=> $stable(NP_ENABLE))
    else $error("enables changed without an enable write");

  chk_sel_capture: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_WR && REG_ADDR == eee_pkg::SEL_ADDR) |=> (state_ff.sel == $past(REG_WDATA)))
    else $error("select byte not captured");

  chk_sel_readback: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_RD && REG_ADDR == eee_pkg::SEL_ADDR) |=> (REG_RDATA == $past(state_ff.sel)))
    else $error("select byte readback wrong");

  chk_off_readback: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_RD && REG_ADDR == eee_pkg::OFF_ADDR) |=> (REG_RDATA == $past(state_ff.off)))
    else $error("offset byte readback wrong");

  chk_rvalid_after_rd: assert property (@(posedge CLOCK) disable iff (RST)
    REG_RD |=> REG_RVALID)
    else $error("read strobe not answered");

  chk_rvalid_idle: assert property (@(posedge CLOCK) disable iff (RST)
    !REG_RD |=> !REG_RVALID)
    else $error("read valid without a read strobe");

  chk_rdata_hold: assert property (@(posedge CLOCK) disable iff (RST)
    !REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");

  chk_unmapped_zero: assert property (@(posedge CLOCK) disable iff (RST)
    (REG_RD && REG_ADDR != eee_pkg::SEL_ADDR && REG_ADDR != eee_pkg::OFF_ADDR
      && REG_ADDR != eee_pkg::DATA_ADDR) |=> REG_RDATA == 8'h00)
    else $error("unmapped address read nonzero");
endmodule // eee_global_indirect_regs

// ---- host_model.sv ----
// Host processor model issuing indirect byte accesses.
// Assumes the device takes strobes on the rising CLOCK edge.
`timescale 1ns/100ps
module host_model (
  input wire logic CLOCK,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID
);
  initial begin
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLOCK);
    REG_WR = 1'b0;
    REG_WDATA = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLOCK);
    REG_RD = 1'b0;
    d = REG_RDATA;
    v = REG_RVALID;
  endtask
  // Select, offset, then data byte
  task automatic wr_ind(input logic [7:0] s, input logic [7:0] o, input logic [7:0] d);
    wr(eee_pkg::SEL_ADDR, s);
    wr(eee_pkg::OFF_ADDR, o);
    wr(eee_pkg::DATA_ADDR, d);
  endtask
  task automatic rd_ind(input logic [7:0] s, input logic [7:0] o, output logic [7:0] d, output logic v);
    wr(eee_pkg::SEL_ADDR, s);
    wr(eee_pkg::OFF_ADDR, o);
    rd(eee_pkg::DATA_ADDR, d, v);
  endtask
endmodule // host_model

// ---- tb_top.sv ----
// Self-checking bench for the global EEE register bank.
// Assumes host_model drives the byte register bus.
`timescale 1ns/100ps
module tb_top;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, d;
  logic REG_WR, REG_RD, REG_RVALID, v;
  logic [3:0] NP_ENABLE, WAKE_ERR_INC;
  logic [3:0] WAKE_ACTIVE = 4'h0;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int pulses = 0;
  int others = 0;
  int first = 0;
  always #2.5 CLOCK = ~CLOCK;
  eee_global_indirect_regs i_dut (.CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .NP_ENABLE(NP_ENABLE), .WAKE_ACTIVE(WAKE_ACTIVE), .WAKE_ERR_INC(WAKE_ERR_INC));
  host_model i_host (.CLOCK(CLOCK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ind(input logic [7:0] s, input logic [7:0] o, input logic [7:0] e);
    i_host.rd_ind(s, o, d, v);
    chk({7'h00, v, d}, {8'h01, e});
  endtask
  // Whole global word table, given the enable nibble
  task automatic read_all(input logic [7:0] np);
    logic [7:0] e [8];
    e = '{8'h68, np, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h01};
    for (int i = 0; i < 8; i++) begin
      chk_ind(8'h20, 8'h34 + 8'(i), e[i]);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(negedge CLOCK);
    RST = 1'b0;
    chk({12'h000, NP_ENABLE}, 16'h000F);
    read_all(8'h0F);
    for (int i = 0; i < 8; i++) begin
      if (i != 1) i_host.wr_ind(8'h20, 8'h34 + 8'(i), 8'hAA);
    end
    i_host.wr_ind(8'h20, 8'h35, 8'h05);
    chk({12'h000, NP_ENABLE}, 16'h0005);
    read_all(8'h05);
    i_host.wr_ind(8'h40, 8'h35, 8'h0A);
    i_host.wr_ind(8'h21, 8'h35, 8'h0A);
    chk({12'h000, NP_ENABLE}, 16'h0005);
    chk_ind(8'h21, 8'h39, 8'h00);
    i_host.rd(eee_pkg::SEL_ADDR, d, v);
    chk({7'h00, v, d}, 16'h0121);
    i_host.rd(eee_pkg::OFF_ADDR, d, v);
    chk({7'h00, v, d}, 16'h0139);
    i_host.rd(8'h10, d, v);
    chk({7'h00, v, d}, 16'h0100);
    for (int i = 0; i < 600; i++) begin
      @(negedge CLOCK);
      if (WAKE_ERR_INC[0] === 1'b1) begin
        pulses++;
        if (first == 0) first = i;
      end
      if (WAKE_ERR_INC[3:1] !== 3'b000) others++;
      WAKE_ACTIVE = {2'b00, i < 513, 1'b1};
    end
    chk(16'(first), 16'd514);
    chk(16'(pulses), 16'd1);
    chk(16'(others), 16'd0);
    // Reset again after the enables were changed
    RST = 1'b1;
    repeat (2) @(negedge CLOCK);
    RST = 1'b0;
    chk({12'h000, NP_ENABLE}, 16'h000F);
    i_host.rd(eee_pkg::SEL_ADDR, d, v);
    chk({7'h00, v, d}, 16'h0100);
    give_verdict();
  end
endmodule // tb_top
